// File: bench/cpu_register_set_bench.sv
// self-checking bench for the cpu register set
`timescale 1ns/1ns
`include "cpu_regs_defines.svh"
module cpu_register_set_bench;
    logic clk_sys = 1'b0, rst_n = 1'b0, advanced_mode = 1'b1;
    logic gpr_wr_en = 1'b0, gpr_wr_upper = 1'b0, pc_load = 1'b0, pc_step = 1'b0;
    logic [2:0] gpr_wr_sel = 3'h0, gpr_rd_sel = 3'h0, irq_level = 3'h0;
    cpu_regs_pkg::size_t gpr_wr_size = cpu_regs_pkg::SZ_LONG, arith_size = cpu_regs_pkg::SZ_BYTE;
    logic [31:0] gpr_wr_data = 32'h0, arith_a = 32'h0, arith_b = 32'h0;
    logic [23:0] pc_load_value = 24'h0, reset_vector = 24'h0;
    cpu_regs_pkg::ctl_op_t ctl_op = cpu_regs_pkg::CTL_NONE;
    logic ctl_target_ext = 1'b0, exc_start = 1'b0, flags_we = 1'b0, arith_op = 1'b0;
    logic [7:0] ctl_operand = 8'h00;
    logic [4:0] flags_in = 5'h00;
    logic arith_sub = 1'b0, irq_req = 1'b1, nmi_req = 1'b1, insn_done = 1'b0;
    cpu_regs_pkg::flag_sel_t br_sel = cpu_regs_pkg::BR_NEG;
    logic mac_clear = 1'b0, mac_acc = 1'b0;
    logic signed [31:0] mac_product = 32'sh0;
    logic [31:0] gpr_rd_data, stack_pointer_reg;
    logic [23:0] program_counter, fetch_addr;
    logic [7:0] ctl_store_data, extended_control, condition_code;
    logic br_flag, irq_accept, nmi_accept, trace_req;
    logic [63:0] multiply_accumulate_result;
    // bench models and bookkeeping
    logic [31:0] gm [8];
    logic [7:0] ext_m, ccr_m;
    logic [63:0] mac_m;
    logic [31:0] seed = 32'h0000003d, v, d;
    logic [23:0] e;
    int err_total = 0, comparisons = 0, i;

    cpu_register_set dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .advanced_mode(advanced_mode),
        .gpr_wr_en(gpr_wr_en), .gpr_wr_sel(gpr_wr_sel), .gpr_wr_size(gpr_wr_size),
        .gpr_wr_upper(gpr_wr_upper), .gpr_wr_data(gpr_wr_data), .gpr_rd_sel(gpr_rd_sel),
        .gpr_rd_data(gpr_rd_data), .stack_pointer_reg(stack_pointer_reg), .pc_load(pc_load),
        .pc_load_value(pc_load_value), .pc_step(pc_step), .program_counter(program_counter),
        .fetch_addr(fetch_addr), .ctl_op(ctl_op), .ctl_target_ext(ctl_target_ext),
        .ctl_operand(ctl_operand), .ctl_store_data(ctl_store_data),
        .extended_control(extended_control), .condition_code(condition_code),
        .exc_start(exc_start), .reset_vector(reset_vector), .flags_we(flags_we),
        .flags_in(flags_in), .arith_op(arith_op), .arith_size(arith_size), .arith_a(arith_a),
        .arith_b(arith_b), .arith_sub(arith_sub), .br_sel(br_sel), .br_flag(br_flag),
        .irq_req(irq_req), .irq_level(irq_level), .nmi_req(nmi_req), .irq_accept(irq_accept),
        .nmi_accept(nmi_accept), .trace_req(trace_req), .insn_done(insn_done),
        .mac_clear(mac_clear), .mac_acc(mac_acc), .mac_product(mac_product),
        .multiply_accumulate_result(multiply_accumulate_result));

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    // fixed-seed lfsr so every run sees the same stimulus
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // lane merge of a partial general register write
    function automatic logic [31:0] merge(input logic [31:0] o, w, input cpu_regs_pkg::size_t s,
                                          input logic up);
        if (s == cpu_regs_pkg::SZ_LONG) return w;
        if (s == cpu_regs_pkg::SZ_WORD) return up ? {w[15:0], o[15:0]} : {o[31:16], w[15:0]};
        return up ? {o[31:16], w[7:0], o[7:0]} : {o[31:8], w[7:0]};
    endfunction

    // carry or borrow out of bit 3, 11 or 27 depending on size
    function automatic logic hc(input logic [31:0] a, b, input logic sub,
                                input cpu_regs_pkg::size_t s);
        int w;
        logic [32:0] m, al, bl, sm;
        w = s == cpu_regs_pkg::SZ_BYTE ? 4 : (s == cpu_regs_pkg::SZ_WORD ? 12 : 28);
        m = (33'h1 << w) - 33'h1;
        al = {1'b0, a} & m;
        bl = {1'b0, b} & m;
        sm = al + bl;
        return sub ? (al < bl) : sm[w];
    endfunction

    function automatic logic irq_exp();
        return irq_req && !ccr_m[7] && (irq_level > ext_m[2:0] || irq_level == 3'h7);
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // reset held for 21 cycles; pc comes from the vector on the first edge after release
    task automatic do_reset();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        reset_vector <= 24'(rnd());
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(extended_control, `CTL_RESET);
        chk(condition_code[`CC_IMASK_BIT], 1'b1);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        // the reset sequence cycle still refuses even the non-maskable request
        @(negedge clk_sys);
        chk(nmi_accept, 1'b0);
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk(program_counter, reset_vector);
        ext_m = `CTL_RESET;
        ccr_m = `CC_RESET;
    endtask

    // one control instruction, then watch the three-state interrupt blackout
    task automatic ctl(input cpu_regs_pkg::ctl_op_t op, input logic tgt, input logic [7:0] w);
        logic [7:0] r;
        @(posedge clk_sys);
        ctl_op <= op;
        ctl_target_ext <= tgt;
        ctl_operand <= w;
        {irq_req, irq_level} <= 4'(rnd());
        @(posedge clk_sys);
        ctl_op <= cpu_regs_pkg::CTL_NONE;
        r = tgt ? ext_m : ccr_m;
        if (op == cpu_regs_pkg::CTL_LOAD) r = w;
        if (op == cpu_regs_pkg::CTL_AND) r = r & w;
        if (op == cpu_regs_pkg::CTL_OR) r = r | w;
        if (op == cpu_regs_pkg::CTL_XOR) r = r ^ w;
        if (tgt) ext_m = r | `CTL_RSV_MASK;
        else ccr_m = r;
        for (int k = 0; k < 4; k++) begin
            @(negedge clk_sys);
            chk(nmi_accept, op == cpu_regs_pkg::CTL_STORE || k == 3);
            chk(irq_accept, (op == cpu_regs_pkg::CTL_STORE || k == 3) && irq_exp());
            if (k < 3) @(posedge clk_sys);
        end
        chk(extended_control, ext_m);
        chk(condition_code, ccr_m);
        chk(ctl_store_data, tgt ? ext_m : ccr_m);
        // trace request follows the trace bit on each completed instruction
        @(posedge clk_sys);
        insn_done <= 1'b1;
        @(negedge clk_sys);
        chk(trace_req, ext_m[`CTL_TRACE_BIT]);
        @(posedge clk_sys);
        insn_done <= 1'b0;
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // watchdog: the whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        summarize();
    end

    initial begin
        do_reset();
        // general registers: whole writes first, then random lanes back to back
        for (i = 0; i < 48; i++) begin
            @(posedge clk_sys);
            v = rnd();
            d = rnd();
            if (i < 8) v[12:8] = {3'(i), 2'h2};
            else v[9:8] = 2'(v[9:8] % 3);
            gpr_wr_en <= 1'b1;
            gpr_wr_sel <= v[12:10];
            gpr_wr_size <= cpu_regs_pkg::size_t'(v[9:8]);
            gpr_wr_upper <= v[13];
            gpr_wr_data <= d;
            gm[v[12:10]] = merge(gm[v[12:10]], d, cpu_regs_pkg::size_t'(v[9:8]), v[13]);
        end
        @(posedge clk_sys);
        gpr_wr_en <= 1'b0;
        for (i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            gpr_rd_sel <= 3'(i);
            @(posedge clk_sys);
            @(negedge clk_sys);
            chk(gpr_rd_data, gm[i]);
        end
        chk(stack_pointer_reg, gm[7]);
        // program counter: odd loads, one step, both address modes, top-end wrap
        for (i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            v = (i == 7) ? 32'h80ffffff : rnd();
            advanced_mode <= v[31];
            pc_load <= 1'b1;
            pc_load_value <= v[23:0];
            @(posedge clk_sys);
            pc_load <= 1'b0;
            pc_step <= 1'b1;
            @(posedge clk_sys);
            pc_step <= 1'b0;
            @(negedge clk_sys);
            e = v[23:0] + 24'h2;
            chk(fetch_addr, e & (v[31] ? 24'hfffffe : 24'h00fffe));
            chk(program_counter, v[31] ? e : (e & 24'h00ffff));
        end
        // corner cases of the control registers, then random operations
        ctl(cpu_regs_pkg::CTL_LOAD, 1'b0, 8'h40);
        ctl(cpu_regs_pkg::CTL_LOAD, 1'b1, 8'h00);
        ctl(cpu_regs_pkg::CTL_STORE, 1'b1, 8'h87);
        ctl(cpu_regs_pkg::CTL_LOAD, 1'b1, 8'h87);
        @(posedge clk_sys);
        exc_start <= 1'b1;
        @(posedge clk_sys);
        exc_start <= 1'b0;
        ccr_m[`CC_IMASK_BIT] = 1'b1;
        ext_m[`CTL_TRACE_BIT] = 1'b0;
        @(negedge clk_sys);
        chk(condition_code, ccr_m);
        chk(extended_control, ext_m);
        for (i = 0; i < 24; i++) begin
            v = rnd();
            ctl(cpu_regs_pkg::ctl_op_t'(3'(v % 5 + 1)), v[8], v[23:16]);
        end
        // flag updates, half carry and branch flag selection
        for (i = 0; i < 24; i++) begin
            @(posedge clk_sys);
            v = rnd();
            d = rnd();
            arith_op <= v[5];
            flags_we <= !v[5];
            flags_in <= v[4:0];
            br_sel <= cpu_regs_pkg::flag_sel_t'(v[7:6]);
            arith_a <= d;
            arith_b <= {d[15:0], v[31:16]};
            arith_sub <= v[8];
            arith_size <= cpu_regs_pkg::size_t'(2'(v[10:9] % 3));
            @(posedge clk_sys);
            arith_op <= 1'b0;
            flags_we <= 1'b0;
            @(negedge clk_sys);
            chk(condition_code[3:0], v[3:0]);
            chk(condition_code[5], v[5] ? hc(arith_a, arith_b, arith_sub, arith_size) : v[4]);
            chk(condition_code[7:6], ccr_m[7:6]);
            chk(br_flag, v[3 - v[7:6]]);
        end
        // multiply-accumulate: clear, then back-to-back signed products
        @(posedge clk_sys);
        mac_clear <= 1'b1;
        mac_m = 64'h0;
        for (i = 0; i < 10; i++) begin
            @(posedge clk_sys);
            d = (i == 0) ? 32'h80000000 : rnd();
            mac_clear <= 1'b0;
            mac_acc <= 1'b1;
            mac_product <= signed'(d);
            mac_m = mac_m + {{32{d[31]}}, d};
        end
        @(posedge clk_sys);
        mac_acc <= 1'b0;
        @(negedge clk_sys);
        chk(multiply_accumulate_result, mac_m);
        do_reset();
        summarize();
    end
endmodule

// File: hw/cpu_register_set.sv
// cpu programmer-visible register set: general registers, pc, control and mac
`timescale 1ns/1ns
`include "cpu_regs_defines.svh"
module cpu_register_set (
    input wire logic clk_sys,                       // 125 MHz cpu clock
    input wire logic rst_n,                         // async reset, active low
    input wire logic advanced_mode,                 // 1 selects 16 Mbyte space
    input wire logic gpr_wr_en,                     // general register write
    input wire logic [2:0] gpr_wr_sel,              // general register number
    input wire cpu_regs_pkg::size_t gpr_wr_size,    // access width
    input wire logic gpr_wr_upper,                  // word: extended half; byte: high
    input wire logic [31:0] gpr_wr_data,            // write data, low aligned
    input wire logic [2:0] gpr_rd_sel,              // general register to read
    output logic [31:0] gpr_rd_data,                // read data, one cycle later
    output logic [31:0] stack_pointer_reg,          // register seven, one cycle late
    input wire logic pc_load,                       // load program counter
    input wire logic [23:0] pc_load_value,          // new pc value
    input wire logic pc_step,                       // advance pc by one word
    output logic [23:0] program_counter,            // current pc
    output logic [23:0] fetch_addr,                 // instruction fetch address
    input wire cpu_regs_pkg::ctl_op_t ctl_op,       // control register instruction
    input wire logic ctl_target_ext,                // 1 targets extended control
    input wire logic [7:0] ctl_operand,             // immediate or loaded value
    output logic [7:0] ctl_store_data,              // value for store instruction
    output logic [7:0] extended_control,            // extended control readback
    output logic [7:0] condition_code,              // condition code readback
    input wire logic exc_start,                     // exception sequence begins
    input wire logic [23:0] reset_vector,           // pc value from vector table
    input wire logic flags_we,                      // update arithmetic flags
    input wire logic [4:0] flags_in,                // half, neg, zero, ovf, carry
    input wire logic arith_op,                      // add/sub/cmp/neg result
    input wire cpu_regs_pkg::size_t arith_size,     // operand size for half carry
    input wire logic [31:0] arith_a,                // first operand
    input wire logic [31:0] arith_b,                // second operand
    input wire logic arith_sub,                     // 1 for subtract, compare, negate
    input wire cpu_regs_pkg::flag_sel_t br_sel,     // flag tested by branch
    output logic br_flag,                           // selected flag value
    input wire logic irq_req,                       // maskable interrupt pending
    input wire logic [2:0] irq_level,               // its priority level
    input wire logic nmi_req,                       // non-maskable interrupt
    output logic irq_accept,                        // maskable interrupt may enter
    output logic nmi_accept,                        // nmi may enter
    output logic trace_req,                         // trace exception after insn
    input wire logic insn_done,                     // an instruction completed
    input wire logic mac_clear,                     // clear multiply-accumulate
    input wire logic mac_acc,                       // accumulate product
    input wire logic signed [31:0] mac_product,     // signed product to add
    output logic [63:0] multiply_accumulate_result  // mac register
);
    gpr_port_if port ();
    logic [1:0] mask_cnt;
    logic [7:0] next_ctl;
    logic reset_seq;
    logic [4:0] half_bits;
    logic [32:0] sum;

    gpr_bank #(.NREG(8)) u_bank (
        .clk_sys(clk_sys),
        .port(port.bank)
    );

    // lane selection per access width and half
    always_comb begin
        port.wr_sel = gpr_wr_sel;
        port.rd_sel = gpr_rd_sel;
        port.wr_lane = 4'h0;
        port.wr_data = gpr_wr_data;
        if (gpr_wr_en) begin
            unique case (gpr_wr_size)
                cpu_regs_pkg::SZ_LONG: port.wr_lane = 4'hf;
                cpu_regs_pkg::SZ_WORD: begin
                    // extended half or lower half, independent 16-bit views
                    port.wr_lane = gpr_wr_upper ? 4'hc : 4'h3;
                    port.wr_data = {gpr_wr_data[15:0], gpr_wr_data[15:0]};
                end
                cpu_regs_pkg::SZ_BYTE: begin
                    // high or low byte of the lower half
                    port.wr_lane = gpr_wr_upper ? 4'h2 : 4'h1;
                    port.wr_data = {4{gpr_wr_data[7:0]}};
                end
                default: port.wr_lane = 4'h0;
            endcase
        end
    end
    assign gpr_rd_data = port.rd_data;
    assign stack_pointer_reg = port.sp_data;

    // first cycle after reset release runs the reset exception sequence
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reset_seq <= 1'b1;
        end else begin
            reset_seq <= 1'b0;
        end
    end

    // program counter; normal mode confines loads and steps to 64 kbytes, the reset vector is taken whole
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            program_counter <= 24'h000000;
        end else if (reset_seq) begin
            program_counter <= reset_vector;
        end else if (pc_load) begin
            program_counter <= advanced_mode ? pc_load_value
                : (pc_load_value & `NORMAL_ADDR_MASK);
        end else if (pc_step) begin
            program_counter <= advanced_mode ? program_counter + 24'h000002
                : ((program_counter + 24'h000002) & `NORMAL_ADDR_MASK);
        end
    end
    // instructions are whole words, so bit zero never reaches the fetch
    assign fetch_addr = {program_counter[23:1], 1'b0};

    // combined result of a control instruction on the selected register
    always_comb begin
        next_ctl = ctl_target_ext ? extended_control : condition_code;
        unique case (ctl_op)
            cpu_regs_pkg::CTL_LOAD: next_ctl = ctl_operand;
            cpu_regs_pkg::CTL_AND: next_ctl = next_ctl & ctl_operand;
            cpu_regs_pkg::CTL_OR: next_ctl = next_ctl | ctl_operand;
            cpu_regs_pkg::CTL_XOR: next_ctl = next_ctl ^ ctl_operand;
            cpu_regs_pkg::CTL_NONE, cpu_regs_pkg::CTL_STORE: next_ctl = next_ctl;
            default: next_ctl = next_ctl;
        endcase
    end
    assign ctl_store_data = ctl_target_ext ? extended_control : condition_code;

    // extended control: reserved bits forced to one whatever is written
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            extended_control <= `CTL_RESET;
        end else if (reset_seq) begin
            extended_control <= `CTL_RESET;
        end else if (ctl_target_ext && ctl_op != cpu_regs_pkg::CTL_NONE
                     && ctl_op != cpu_regs_pkg::CTL_STORE) begin
            extended_control <= next_ctl | `CTL_RSV_MASK;
        end else if (exc_start) begin
            // exception entry stops tracing inside the handler
            extended_control[`CTL_TRACE_BIT] <= 1'b0;
        end
    end

    // half carry out of bit 3, 11 or 27 by operand size
    assign sum = arith_sub ? ({1'b0, arith_a} - {1'b0, arith_b})
                           : ({1'b0, arith_a} + {1'b0, arith_b});
    always_comb begin
        half_bits = flags_in;
        if (arith_op) begin
            unique case (arith_size)
                cpu_regs_pkg::SZ_BYTE:
                    half_bits[4] = sum[4] ^ arith_a[4] ^ arith_b[4];
                cpu_regs_pkg::SZ_WORD:
                    half_bits[4] = sum[12] ^ arith_a[12] ^ arith_b[12];
                cpu_regs_pkg::SZ_LONG:
                    half_bits[4] = sum[28] ^ arith_a[28] ^ arith_b[28];
                default: half_bits[4] = 1'b0;
            endcase
        end
    end

    // condition code: exception entry sets the mask and wins over a write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            condition_code <= `CC_RESET;
        end else if (reset_seq || exc_start) begin
            condition_code[`CC_IMASK_BIT] <= 1'b1;
        end else if (!ctl_target_ext && ctl_op != cpu_regs_pkg::CTL_NONE
                     && ctl_op != cpu_regs_pkg::CTL_STORE) begin
            condition_code <= next_ctl;
        end else if (flags_we || arith_op) begin
            condition_code[5] <= half_bits[4];
            condition_code[3:0] <= half_bits[3:0];
        end
    end

    // branch condition source
    always_comb begin
        unique case (br_sel)
            cpu_regs_pkg::BR_NEG: br_flag = condition_code[`CC_NEG_BIT];
            cpu_regs_pkg::BR_ZERO: br_flag = condition_code[`CC_ZERO_BIT];
            cpu_regs_pkg::BR_OVF: br_flag = condition_code[`CC_OVF_BIT];
            cpu_regs_pkg::BR_CARRY: br_flag = condition_code[`CC_CARRY_BIT];
            default: br_flag = 1'b0;
        endcase
    end

    // masking window after a control write lets the new mask settle first
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mask_cnt <= 2'h0;
        end else if (ctl_op != cpu_regs_pkg::CTL_NONE && ctl_op != cpu_regs_pkg::CTL_STORE) begin
            mask_cnt <= 2'(`MASK_WINDOW_STATES);
        end else if (mask_cnt != 2'h0) begin
            mask_cnt <= mask_cnt - 2'h1;
        end
    end

    // user bit plays no part in masking; level 7 always passes the level test
    assign irq_accept = irq_req && mask_cnt == 2'h0 && !reset_seq
        && !condition_code[`CC_IMASK_BIT]
        && (irq_level > extended_control[2:0] || irq_level == 3'h7);
    assign nmi_accept = nmi_req && mask_cnt == 2'h0 && !reset_seq;
    assign trace_req = insn_done && extended_control[`CTL_TRACE_BIT];

    // 64-bit multiply-accumulate register, not reset
    always_ff @(posedge clk_sys) begin
        if (mac_clear) begin
            multiply_accumulate_result <= 64'h0;
        end else if (mac_acc) begin
            multiply_accumulate_result <= multiply_accumulate_result
                + 64'(signed'(mac_product));
        end
    end

    property p_window;
        @(posedge clk_sys) disable iff (!rst_n)
        (ctl_op == cpu_regs_pkg::CTL_LOAD) |=> !nmi_accept [*3];
    endproperty
    a_window: assert property (p_window) else $error("nmi not masked after load");
    property p_store_no_window;
        @(posedge clk_sys) disable iff (!rst_n)
        (ctl_op == cpu_regs_pkg::CTL_STORE && mask_cnt == 2'h0) |=> mask_cnt == 2'h0;
    endproperty
    a_store_no_window: assert property (p_store_no_window) else $error("store opened window");
    property p_rsv;
        @(posedge clk_sys) disable iff (!rst_n)
        (extended_control & `CTL_RSV_MASK) == `CTL_RSV_MASK;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not one");
    property p_fetch;
        @(posedge clk_sys) disable iff (!rst_n) !fetch_addr[0];
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch address odd");
    property p_imask;
        @(posedge clk_sys) disable iff (!rst_n)
        condition_code[`CC_IMASK_BIT] |-> !irq_accept;
    endproperty
    a_imask: assert property (p_imask) else $error("irq accepted while masked");
    property p_exc;
        @(posedge clk_sys) disable iff (!rst_n)
        exc_start |=> condition_code[`CC_IMASK_BIT];
    endproperty
    a_exc: assert property (p_exc) else $error("mask not set on exception");
    property p_trace;
        @(posedge clk_sys) disable iff (!rst_n)
        (insn_done && !extended_control[`CTL_TRACE_BIT]) |-> !trace_req;
    endproperty
    a_trace: assert property (p_trace) else $error("trace without trace bit");
    property p_normal;
        @(posedge clk_sys) disable iff (!rst_n)
        (pc_load && !advanced_mode && !reset_seq) |=> program_counter[23:16] == 8'h00;
    endproperty
    a_normal: assert property (p_normal) else $error("pc beyond 64 kbytes");
    // the edge that releases reset still sees rst_n low, so only the next edge counts
    property p_reset_seq;
        @(posedge clk_sys) disable iff (!rst_n)
        (reset_seq && rst_n) |=> program_counter == $past(reset_vector);
    endproperty
    a_reset_seq: assert property (p_reset_seq) else $error("pc not from vector");
    property p_pc_step;
        @(posedge clk_sys) disable iff (!rst_n)
        (pc_step && !pc_load && !reset_seq && advanced_mode)
            |=> program_counter == $past(program_counter) + 24'h000002;
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc did not advance a word");
    property p_exc_trace;
        @(posedge clk_sys) disable iff (!rst_n)
        (exc_start && ctl_op == cpu_regs_pkg::CTL_NONE) |=> !extended_control[`CTL_TRACE_BIT];
    endproperty
    a_exc_trace: assert property (p_exc_trace) else $error("trace kept on exception");
    property p_cc_load;
        @(posedge clk_sys) disable iff (!rst_n)
        (!ctl_target_ext && ctl_op == cpu_regs_pkg::CTL_LOAD && !exc_start && !reset_seq)
            |=> condition_code == $past(ctl_operand);
    endproperty
    a_cc_load: assert property (p_cc_load) else $error("condition code load lost");
    property p_ext_level;
        @(posedge clk_sys) disable iff (!rst_n)
        (ctl_target_ext && ctl_op == cpu_regs_pkg::CTL_LOAD && !reset_seq)
            |=> extended_control[2:0] == $past(ctl_operand[2:0]);
    endproperty
    a_ext_level: assert property (p_ext_level) else $error("mask level not loaded");
    c_load: cover property (@(posedge clk_sys) ctl_op == cpu_regs_pkg::CTL_LOAD && ctl_target_ext);
    c_irq: cover property (@(posedge clk_sys) irq_accept);
    c_trace: cover property (@(posedge clk_sys) trace_req);
    c_exc: cover property (@(posedge clk_sys) exc_start && extended_control[`CTL_TRACE_BIT]);
endmodule

// File: hw/cpu_regs_defines.svh
// timing counts, field positions and reset values for the cpu register set
`ifndef CPU_REGS_DEFINES_SVH
`define CPU_REGS_DEFINES_SVH
`define CTL_TRACE_BIT 7
`define CTL_RSV_HI 6
`define CTL_RSV_LO 3
`define CTL_RESET 8'h7f
`define CTL_RSV_MASK 8'h78
`define CC_IMASK_BIT 7
`define CC_USER_BIT 6
`define CC_HALF_BIT 5
`define CC_NEG_BIT 3
`define CC_ZERO_BIT 2
`define CC_OVF_BIT 1
`define CC_CARRY_BIT 0
`define CC_RESET 8'h80
`define MASK_WINDOW_STATES 3
`define NORMAL_ADDR_MASK 24'h00ffff
`endif

// File: hw/cpu_regs_pkg.sv
// types shared by the cpu register set
package cpu_regs_pkg;
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_LONG = 2'b10
    } size_t;
    typedef enum logic [2:0] {
        CTL_NONE = 3'b000,
        CTL_LOAD = 3'b001,
        CTL_STORE = 3'b010,
        CTL_AND = 3'b011,
        CTL_OR = 3'b100,
        CTL_XOR = 3'b101
    } ctl_op_t;
    typedef enum logic [1:0] {
        BR_NEG = 2'b00,
        BR_ZERO = 2'b01,
        BR_OVF = 2'b10,
        BR_CARRY = 2'b11
    } flag_sel_t;
endpackage

// File: hw/gpr_bank.sv
// eight 32-bit general registers with byte-lane writes and registered read
`timescale 1ns/1ns
module gpr_bank #(
    parameter int NREG = 8
) (
    input wire logic clk_sys, // system clock
    gpr_port_if.bank port     // register access port
);
    logic [31:0] mem [NREG];
    // no reset: contents stay uninitialised, software loads the stack pointer first
    always_ff @(posedge clk_sys) begin
        for (int l = 0; l < 4; l++) begin
            if (port.wr_lane[l]) begin
                mem[port.wr_sel][l*8 +: 8] <= port.wr_data[l*8 +: 8];
            end
        end
    end
    // read data from a register, as the memory style asks
    always_ff @(posedge clk_sys) begin
        port.rd_data <= mem[port.rd_sel];
        port.sp_data <= mem[NREG-1];
    end
endmodule

// File: hw/gpr_port_if.sv
// write and read port between the register set and its general register bank
`timescale 1ns/1ns
interface gpr_port_if;
    logic [2:0] wr_sel;
    logic [3:0] wr_lane;
    logic [31:0] wr_data;
    logic [2:0] rd_sel;
    logic [31:0] rd_data;
    logic [31:0] sp_data;
    modport ctrl (output wr_sel, wr_lane, wr_data, rd_sel, input rd_data, sp_data);
    modport bank (input wr_sel, wr_lane, wr_data, rd_sel, output rd_data, sp_data);
endinterface
